// [rtl/lpsr_pkg.sv]
// constants, register map and field layouts of the light and proximity sensor register bank
package lpsr_pkg;
    // register offsets
    localparam logic [7:0] ADDR_ID = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h01;
    localparam logic [7:0] ADDR_INT = 8'h02;
    localparam logic [7:0] ADDR_NEAR_LO = 8'h03;
    localparam logic [7:0] ADDR_NEAR_HI = 8'h04;
    localparam logic [7:0] ADDR_LT_LOW = 8'h05;
    localparam logic [7:0] ADDR_LT_NIB = 8'h06;
    localparam logic [7:0] ADDR_UT_HIGH = 8'h07;
    localparam logic [7:0] ADDR_NEAR_RES = 8'h08;
    localparam logic [7:0] ADDR_LR_LOW = 8'h09;
    localparam logic [7:0] ADDR_LR_HIGH = 8'h0a;
    // serial slave identifier, 7 bits
    localparam logic [6:0] DEV_ADDR = 7'h44;
    // identity value is arbitrary
    localparam logic [7:0] ID_VALUE = 8'h5a;
    // values after reset
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] INT_RESET = 8'h00;
    localparam logic [7:0] NEAR_LO_RESET = 8'h00;
    localparam logic [7:0] NEAR_HI_RESET = 8'hff;
    localparam logic [7:0] LT_LOW_RESET = 8'h00;
    localparam logic [7:0] LT_NIB_RESET = 8'hf0;
    localparam logic [7:0] UT_HIGH_RESET = 8'hff;
    // bit 4 is the low bit of the idle code, so every configuration bit is stored
    localparam logic [7:0] CFG_MASK = 8'hff;
    // field positions
    localparam int NEAR_FLAG_BIT = 7;
    localparam int LIGHT_FLAG_BIT = 3;
    localparam logic [2:0] IDLE_NONE = 3'h7;
    // timing, clock period and times in ns
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned PROX_CONV_NS = 540000;
    localparam int unsigned PROX_CONV_CYC = (PROX_CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned IDLE_UNIT_NS = 12500000;
    localparam int unsigned IDLE_UNIT_CYC = IDLE_UNIT_NS / CLK_NS;

    typedef struct packed {
        logic prox_en;
        logic [2:0] idle;
        logic emitter;
        logic light_en;
        logic fsr;
        logic spectrum;
    } lpsr_cfg_t;

    typedef struct packed {
        logic near_flag;
        logic [1:0] near_pers;
        logic zero;
        logic light_flag;
        logic [1:0] light_pers;
        logic combine;
    } lpsr_int_t;

    // idle interval in units of 12.5 ms: 800,400,200,100,75,50,12.5,0 ms
    function automatic logic [6:0] idle_mult(input logic [2:0] code);
        unique case (code)
            3'h0: idle_mult = 7'h40;
            3'h1: idle_mult = 7'h20;
            3'h2: idle_mult = 7'h10;
            3'h3: idle_mult = 7'h08;
            3'h4: idle_mult = 7'h06;
            3'h5: idle_mult = 7'h04;
            3'h6: idle_mult = 7'h01;
            3'h7: idle_mult = 7'h00;
        endcase
    endfunction

    // consecutive conversions needed: 1, 4, 8, 16
    function automatic logic [4:0] pers_n(input logic [1:0] code);
        unique case (code)
            2'h0: pers_n = 5'h01;
            2'h1: pers_n = 5'h04;
            2'h2: pers_n = 5'h08;
            2'h3: pers_n = 5'h10;
        endcase
    endfunction

    // saturating run counter
    function automatic logic [4:0] sat_inc(input logic [4:0] c);
        sat_inc = (c == 5'h10) ? c : c + 5'h01;
    endfunction
endpackage

// [rtl/lpsr_regs.sv]
// register bank, serial slave and proximity sequencer of the light and proximity sensor
`timescale 1ns/100ps
module lpsr_regs #(
    parameter int unsigned CONV_CYC = lpsr_pkg::PROX_CONV_CYC,
    parameter int unsigned IDLE_UNIT_CYC = lpsr_pkg::IDLE_UNIT_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // open-drain interrupt pin
    output logic int_out,
    output logic int_oe,
    // proximity front end
    output logic emitter_pulse,
    output logic emitter_current_select,
    output logic near_conv_done,
    input wire logic [7:0] near_sample,
    // light front end
    output logic light_sensing_enable,
    output logic light_full_scale_select,
    input wire logic light_done,
    input wire logic [11:0] light_visible,
    input wire logic [11:0] light_ir
);
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD} lpsr_bus_t;
    typedef enum logic [1:0] {P_OFF, P_CONV, P_IDLE} lpsr_prox_t;

    logic [2:0] scl_sy, sda_sy;
    logic scl_p, sda_p, start_c, stop_c, rise_c, fall_c;
    lpsr_bus_t st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sr, next_sr, tx, next_tx, ptr, next_ptr;
    logic oe, next_oe, mack, next_mack;
    logic wr_stb;
    logic [7:0] wr_addr, wr_data;
    lpsr_pkg::lpsr_cfg_t cfg, next_cfg;
    lpsr_pkg::lpsr_int_t intr, next_intr;
    logic [7:0] near_lo, near_hi, lt_low, lt_nib, ut_high, near_res;
    logic [7:0] next_near_lo, next_near_hi, next_lt_low, next_lt_nib, next_ut_high, next_near_res;
    logic [11:0] lr, next_lr, l_val;
    logic [4:0] pcnt, next_pcnt, lcnt, next_lcnt;
    lpsr_prox_t pst, next_pst;
    logic [31:0] ptimer, next_ptimer;
    logic near_done, l_done, hi_q, p_set, p_clr, l_out, l_set;

    // register read decode, shared by address phase and burst reads
    function automatic logic [7:0] rd(input logic [7:0] a);
        unique case (a)
            lpsr_pkg::ADDR_ID: rd = lpsr_pkg::ID_VALUE;
            lpsr_pkg::ADDR_CFG: rd = cfg;
            lpsr_pkg::ADDR_INT: rd = intr;
            lpsr_pkg::ADDR_NEAR_LO: rd = near_lo;
            lpsr_pkg::ADDR_NEAR_HI: rd = near_hi;
            lpsr_pkg::ADDR_LT_LOW: rd = lt_low;
            lpsr_pkg::ADDR_LT_NIB: rd = lt_nib;
            lpsr_pkg::ADDR_UT_HIGH: rd = ut_high;
            lpsr_pkg::ADDR_NEAR_RES: rd = near_res;
            lpsr_pkg::ADDR_LR_LOW: rd = lr[7:0];
            lpsr_pkg::ADDR_LR_HIGH: rd = {4'h0, lr[11:8]};
            default: rd = 8'h00;
        endcase
    endfunction

    // pointer rolls over after the last register
    function automatic logic [7:0] inc(input logic [7:0] a);
        inc = (a >= lpsr_pkg::ADDR_LR_HIGH) ? lpsr_pkg::ADDR_ID : a + 8'h01;
    endfunction

    // pin synchronisers; stage 0 feeds only stage 1, stage 2 is the edge history
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
        end
        else if (clk_en)
        begin
            scl_sy <= {scl_sy[1:0], scl_in};
            sda_sy <= {sda_sy[1:0], sda_in};
        end
    end

    // bus conditions from synchronised levels
    assign scl_p = scl_sy[1];
    assign sda_p = sda_sy[1];
    assign start_c = scl_p && scl_sy[2] && sda_sy[2] && !sda_p;
    assign stop_c = scl_p && scl_sy[2] && !sda_sy[2] && sda_p;
    assign rise_c = scl_p && !scl_sy[2];
    assign fall_c = !scl_p && scl_sy[2];

    // serial slave; data commits per acknowledged byte so a stop mid-byte writes nothing
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_sr = sr;
        next_tx = tx;
        next_ptr = ptr;
        next_oe = oe;
        next_mack = mack;
        wr_stb = 1'b0;
        if (start_c)
        begin
            next_st = ST_DEV;
            next_cnt = 4'h0;
            next_oe = 1'b0;
        end
        else if (stop_c)
        begin
            next_st = ST_IDLE;
            next_oe = 1'b0;
        end
        else if (st != ST_IDLE && rise_c)
        begin
            if (cnt < 4'h8)
                next_sr = {sr[6:0], sda_p};
            else if (st == ST_RD)
                next_mack = !sda_p;
            next_cnt = cnt + 4'h1;
        end
        else if (st != ST_IDLE && fall_c)
        begin
            if (cnt == 4'h8)
            begin
                next_oe = 1'b1;
                unique case (st)
                    ST_DEV:
                    begin
                        if (sr[7:1] != lpsr_pkg::DEV_ADDR)
                        begin
                            next_st = ST_IDLE;
                            next_oe = 1'b0;
                        end
                        else if (sr[0])
                        begin
                            next_st = ST_RD;
                            next_tx = rd(ptr);
                        end
                        else
                            next_st = ST_REG;
                    end
                    ST_REG:
                    begin
                        next_ptr = sr;
                        next_st = ST_WR;
                    end
                    ST_WR:
                    begin
                        wr_stb = 1'b1;
                        next_ptr = inc(ptr);
                    end
                    ST_RD:
                    begin
                        next_oe = 1'b0;
                        next_ptr = inc(ptr);
                        next_tx = rd(inc(ptr));
                    end
                    default: next_oe = 1'b0;
                endcase
            end
            else if (cnt == 4'h9)
            begin
                next_cnt = 4'h0;
                next_oe = 1'b0;
                if (st == ST_RD && mack)
                    next_oe = !tx[7];
                else if (st == ST_RD)
                    next_st = ST_IDLE;
            end
            else if (st == ST_RD && cnt != 4'h0)
            begin
                next_tx = {tx[6:0], 1'b0};
                next_oe = !tx[6];
            end
        end
    end

    assign wr_addr = ptr;
    assign wr_data = sr;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            st <= ST_IDLE;
            cnt <= 4'h0;
            sr <= 8'h00;
            tx <= 8'h00;
            ptr <= lpsr_pkg::ADDR_ID;
            oe <= 1'b0;
            mack <= 1'b0;
        end
        else if (clk_en)
        begin
            st <= next_st;
            cnt <= next_cnt;
            sr <= next_sr;
            tx <= next_tx;
            ptr <= next_ptr;
            oe <= next_oe;
            mack <= next_mack;
        end
    end

    // selected light spectrum and window test
    assign l_val = cfg.spectrum ? light_ir : light_visible;
    assign l_done = light_done && cfg.light_en;
    assign l_out = l_val <= {lt_nib[3:0], lt_low} || l_val >= {ut_high, lt_nib[7:4]};
    assign hi_q = near_sample >= near_hi;

    // registers, proximity sequencer and flag logic
    always_comb
    begin
        next_cfg = cfg;
        next_intr = intr;
        next_near_lo = near_lo;
        next_near_hi = near_hi;
        next_lt_low = lt_low;
        next_lt_nib = lt_nib;
        next_ut_high = ut_high;
        next_near_res = near_res;
        next_lr = lr;
        next_pcnt = pcnt;
        next_lcnt = lcnt;
        next_pst = pst;
        next_ptimer = ptimer;
        near_done = 1'b0;
        // sequencer: a timer per phase; disable always wins
        unique case (pst)
            P_OFF:
            begin
                if (cfg.prox_en)
                begin
                    next_pst = P_CONV;
                    next_ptimer = CONV_CYC - 1;
                end
            end
            P_CONV:
            begin
                if (!cfg.prox_en)
                    next_pst = P_OFF;
                else if (ptimer == 32'h0)
                begin
                    near_done = 1'b1;
                    next_pst = P_IDLE;
                    next_ptimer = 32'(lpsr_pkg::idle_mult(cfg.idle)) * IDLE_UNIT_CYC - 1;
                    if (cfg.idle == lpsr_pkg::IDLE_NONE)
                    begin
                        next_pst = P_CONV;
                        next_ptimer = CONV_CYC - 1;
                    end
                end
                else
                    next_ptimer = ptimer - 32'h1;
            end
            P_IDLE:
            begin
                if (!cfg.prox_en)
                    next_pst = P_OFF;
                else if (ptimer == 32'h0)
                begin
                    next_pst = P_CONV;
                    next_ptimer = CONV_CYC - 1;
                end
                else
                    next_ptimer = ptimer - 32'h1;
            end
        endcase
        // near result and run of high samples
        p_set = 1'b0;
        p_clr = 1'b0;
        if (near_done)
        begin
            next_near_res = near_sample;
            next_pcnt = hi_q ? lpsr_pkg::sat_inc(pcnt) : 5'h00;
            p_set = hi_q && lpsr_pkg::sat_inc(pcnt) >= lpsr_pkg::pers_n(intr.near_pers);
            p_clr = near_sample < near_lo;
        end
        // light result and run of out-of-window samples
        l_set = 1'b0;
        if (l_done)
        begin
            next_lr = l_val;
            next_lcnt = l_out ? lpsr_pkg::sat_inc(lcnt) : 5'h00;
            l_set = l_out && lpsr_pkg::sat_inc(lcnt) >= lpsr_pkg::pers_n(intr.light_pers);
        end
        // host writes; identity and results ignore writes
        if (wr_stb)
        begin
            unique case (wr_addr)
                // bit 4 kept as idle code bit
                lpsr_pkg::ADDR_CFG: next_cfg = wr_data & lpsr_pkg::CFG_MASK;
                lpsr_pkg::ADDR_INT:
                begin
                    next_intr.near_pers = wr_data[6:5];
                    next_intr.light_pers = wr_data[2:1];
                    next_intr.combine = wr_data[0];
                    if (!wr_data[lpsr_pkg::NEAR_FLAG_BIT])
                        next_intr.near_flag = 1'b0;
                    if (!wr_data[lpsr_pkg::LIGHT_FLAG_BIT])
                        next_intr.light_flag = 1'b0;
                end
                lpsr_pkg::ADDR_NEAR_LO: next_near_lo = wr_data;
                lpsr_pkg::ADDR_NEAR_HI: next_near_hi = wr_data;
                lpsr_pkg::ADDR_LT_LOW: next_lt_low = wr_data;
                lpsr_pkg::ADDR_LT_NIB: next_lt_nib = wr_data;
                lpsr_pkg::ADDR_UT_HIGH: next_ut_high = wr_data;
                default: next_intr.zero = 1'b0;
            endcase
        end
        // hardware clear after the software path, hardware set last so it wins
        if (p_clr)
            next_intr.near_flag = 1'b0;
        if (p_set)
            next_intr.near_flag = 1'b1;
        if (l_set)
            next_intr.light_flag = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cfg <= lpsr_pkg::CFG_RESET;
            intr <= lpsr_pkg::INT_RESET;
            near_lo <= lpsr_pkg::NEAR_LO_RESET;
            near_hi <= lpsr_pkg::NEAR_HI_RESET;
            lt_low <= lpsr_pkg::LT_LOW_RESET;
            lt_nib <= lpsr_pkg::LT_NIB_RESET;
            ut_high <= lpsr_pkg::UT_HIGH_RESET;
            near_res <= 8'h00;
            lr <= 12'h000;
            pcnt <= 5'h00;
            lcnt <= 5'h00;
            pst <= P_OFF;
            ptimer <= 32'h0;
        end
        else if (clk_en)
        begin
            cfg <= next_cfg;
            intr <= next_intr;
            near_lo <= next_near_lo;
            near_hi <= next_near_hi;
            lt_low <= next_lt_low;
            lt_nib <= next_lt_nib;
            ut_high <= next_ut_high;
            near_res <= next_near_res;
            lr <= next_lr;
            pcnt <= next_pcnt;
            lcnt <= next_lcnt;
            pst <= next_pst;
            ptimer <= next_ptimer;
        end
    end

    // pins and front-end controls
    assign sda_out = 1'b0;
    assign sda_oe = oe;
    assign int_out = 1'b0;
    assign int_oe = intr.combine ? (intr.near_flag && intr.light_flag) : (intr.near_flag || intr.light_flag);
    assign emitter_pulse = pst == P_CONV;
    assign emitter_current_select = cfg.emitter;
    assign near_conv_done = near_done && clk_en;
    assign light_sensing_enable = cfg.light_en;
    assign light_full_scale_select = cfg.fsr;

    default clocking dcb @(posedge clk_sys iff clk_en);
    endclocking
    default disable iff (!reset_n);

    sequence s_cfg_wr;
        wr_stb && wr_addr == lpsr_pkg::ADDR_CFG;
    endsequence
    sequence s_near_end;
        near_done && hi_q && intr.near_pers == 2'h0;
    endsequence

    property p_cfg_reset;
        $rose(reset_n) |-> cfg == lpsr_pkg::CFG_RESET && !emitter_pulse;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not clear after reset");
    property p_spectrum;
        l_done |=> lr == $past(l_val);
    endproperty
    a_spectrum: assert property (p_spectrum) else $error("light result not selected spectrum");
    property p_range;
        s_cfg_wr |=> light_full_scale_select == $past(wr_data[1]);
    endproperty
    a_range: assert property (p_range) else $error("range select not taken");
    property p_light_stop;
        !cfg.light_en |=> $stable(lr);
    endproperty
    a_light_stop: assert property (p_light_stop) else $error("light result moved while disabled");
    property p_emitter;
        s_cfg_wr |=> emitter_current_select == $past(wr_data[3]);
    endproperty
    a_emitter: assert property (p_emitter) else $error("emitter current not taken");
    property p_no_idle;
        near_done && cfg.idle == lpsr_pkg::IDLE_NONE && cfg.prox_en |=> emitter_pulse;
    endproperty
    a_no_idle: assert property (p_no_idle) else $error("idle taken with idle disabled");
    property p_conv_hold;
        $rose(emitter_pulse) ##0 cfg.prox_en [*2] |=> emitter_pulse;
    endproperty
    a_conv_hold: assert property (p_conv_hold) else $error("conversion ended early");
    property p_prox_off;
        !cfg.prox_en |=> !emitter_pulse && !near_done;
    endproperty
    a_prox_off: assert property (p_prox_off) else $error("proximity active while disabled");
    property p_int_zero;
        intr.zero == 1'b0;
    endproperty
    a_int_zero: assert property (p_int_zero) else $error("interrupt bit 4 set");
    property p_int_clr;
        wr_stb && wr_addr == lpsr_pkg::ADDR_INT && !wr_data[7] && !wr_data[3] && !near_done && !l_done
            |=> !int_oe;
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt not released");
    property p_pers_one;
        s_near_end |=> intr.near_flag ##1 1'b1;
    endproperty
    a_pers_one: assert property (p_pers_one) else $error("near flag not set");
    property p_near_clr;
        near_done && near_sample < near_lo && !p_set |=> !intr.near_flag;
    endproperty
    a_near_clr: assert property (p_near_clr) else $error("near flag not auto cleared");
endmodule

// [tb/lpsr_host.sv]
// serial bus master model for the sensor's two-wire port
`timescale 1ns/100ps
module lpsr_host (
    // clock
    input wire logic clk_sys,
    // device drive of the data pin
    input wire logic sda_out,
    input wire logic sda_oe,
    // bus lines as seen on the wires
    output logic scl,
    output logic sda,
    // byte read back
    output logic rd_valid,
    output logic [7:0] rd_data
);
    logic sda_drv = 1'b1;
    // pulled-up wire: low when either party pulls it
    assign sda = sda_drv & ~(sda_oe & ~sda_out);
    initial scl = 1'b1;
    initial rd_valid = 1'b0;
    initial rd_data = 8'h00;
    // every change lands just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // data moves two cycles after the clock falls so no false start or stop is seen
    task automatic bit_xfer(input logic b, output logic s);
        tick(2);
        sda_drv = b;
        tick(6);
        scl = 1'b1;
        tick(4);
        s = sda;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_drv = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_drv = 1'b0;
        tick(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_drv = 1'b0;
        tick(6);
        scl = 1'b1;
        tick(8);
        sda_drv = 1'b1;
        tick(8);
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ack_bit, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], q[i]);
        bit_xfer(ack_bit, a);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        start();
        xbyte({lpsr_pkg::DEV_ADDR, 1'b0}, 1'b1, q);
        xbyte(a, 1'b1, q);
        xbyte(d, 1'b1, q);
        stop();
    endtask
    // single byte read, ended by a missing acknowledge
    task automatic read_reg(input logic [7:0] a);
        logic [7:0] q;
        start();
        xbyte({lpsr_pkg::DEV_ADDR, 1'b0}, 1'b1, q);
        xbyte(a, 1'b1, q);
        start();
        xbyte({lpsr_pkg::DEV_ADDR, 1'b1}, 1'b1, q);
        xbyte(8'hff, 1'b1, q);
        stop();
        rd_data = q;
        rd_valid = 1'b1;
        tick(1);
        rd_valid = 1'b0;
    endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the sensor register bank
`timescale 1ns/100ps
module tb_top;
    localparam int unsigned CONV = 4;
    localparam int unsigned UNIT = 8;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic light_done = 1'b0;
    logic [11:0] light_visible = 12'h000;
    logic [11:0] light_ir = 12'h000;
    logic [7:0] near_sample = 8'h50;
    logic scl, sda, sda_out, sda_oe, int_out, int_oe, rd_valid, near_conv_done;
    logic emitter_pulse, emitter_current_select, light_sensing_enable, light_full_scale_select;
    logic [7:0] rd_data;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int n_tests = 0;
    int mult[8] = '{64, 32, 16, 8, 6, 4, 1, 0};
    logic [7:0] rst_v[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00, 8'h00};
    lpsr_regs #(.CONV_CYC(CONV), .IDLE_UNIT_CYC(UNIT)) dut_u (.clk_sys, .reset_n, .clk_en(1'b1), .scl_in(scl),
        .sda_in(sda), .sda_out, .sda_oe, .int_out, .int_oe, .emitter_pulse, .emitter_current_select,
        .near_conv_done, .near_sample, .light_sensing_enable, .light_full_scale_select, .light_done,
        .light_visible, .light_ir);
    lpsr_host host_u (.clk_sys, .sda_out, .sda_oe, .scl, .sda, .rd_valid, .rd_data);
    // 200 MHz clock
    initial
        forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.read_reg(a);
    endtask
    task automatic light(input logic [11:0] vi, input logic [11:0] ir);
        @(posedge clk_sys);
        #1 light_done = 1'b1;
        light_visible = vi;
        light_ir = ir;
        @(posedge clk_sys);
        #1 light_done = 1'b0;
    endtask
    // bounded wait for a conversion end; returns cycles waited
    task automatic wait_done(output int n);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (near_conv_done !== 1'b1 && n < 1000);
    endtask
    // each read byte meets the oldest note
    always @(posedge clk_sys)
        if (rd_valid === 1'b1)
            chk("read data", {4'h0, exp_q.pop_front()}, {4'h0, rd_data});
    // cut a hang short
    initial
    begin
        #400us;
        n_mismatch++;
        conclude();
    end
    // main sequence
    initial
    begin
        int n, k;
        logic [11:0] v, r;
        void'($urandom(32'hece3ffdb));
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        chk("idle pins", 12'h0, {sda_oe, int_oe, emitter_pulse, near_conv_done, light_sensing_enable});
        // identity register left alone
        for (int a = 1; a < 11; a++)
            rd(a[7:0], rst_v[a]);
        host_u.write_reg(8'h01, 8'h1e);
        rd(8'h01, 8'h1e);
        chk("cfg pins", 12'h7, {emitter_current_select, light_sensing_enable, light_full_scale_select});
        host_u.write_reg(8'h01, 8'h00);
        host_u.write_reg(8'h08, 8'h55);
        host_u.write_reg(8'h0a, 8'h55);
        rd(8'h08, 8'h00);
        rd(8'h0a, 8'h00);
        host_u.write_reg(8'h04, 8'h80);
        host_u.write_reg(8'h03, 8'h20);
        host_u.write_reg(8'h02, 8'h20);
        host_u.write_reg(8'h01, 8'hf0);
        wait_done(n);
        #1 near_sample = 8'h80;
        k = 0;
        do
        begin
            wait_done(n);
            k++;
            repeat (2) @(posedge clk_sys);
        end
        while (int_oe !== 1'b1 && k < 20);
        chk("near persistence", k[11:0], 12'h4);
        rd(8'h08, 8'h80);
        rd(8'h02, 8'ha0);
        near_sample = 8'h1f;
        wait_done(n);
        wait_done(n);
        repeat (2) @(posedge clk_sys);
        chk("near auto clear", 12'h0, {11'h0, int_oe});
        // every idle code, period between conversion ends
        for (int c = 0; c < 8; c++)
        begin
            host_u.write_reg(8'h01, {1'b1, c[2:0], 4'h0});
            wait_done(n);
            wait_done(n);
            chk("idle period", 12'(CONV + mult[c] * UNIT), n[11:0]);
        end
        // single qualifying sample sets the near flag, then a low sample clears it
        near_sample = 8'h90;
        host_u.write_reg(8'h02, 8'h00);
        wait_done(n);
        repeat (2) @(posedge clk_sys);
        chk("single sample flag", 12'h1, {11'h0, int_oe});
        #1 near_sample = 8'h10;
        wait_done(n);
        repeat (2) @(posedge clk_sys);
        chk("low sample clear", 12'h0, {11'h0, int_oe});
        host_u.write_reg(8'h01, 8'h00);
        k = 0;
        repeat (600) @(posedge clk_sys) k += int'(emitter_pulse | near_conv_done);
        chk("pulses when off", 12'h0, k[11:0]);
        host_u.write_reg(8'h01, 8'h04);
        v = 12'($urandom_range(4094, 1));
        r = 12'($urandom_range(4094, 1));
        light(v, r);
        rd(8'h09, v[7:0]);
        rd(8'h0a, {4'h0, v[11:8]});
        rd(8'h02, 8'h00);
        host_u.write_reg(8'h01, 8'h05);
        light(v, r);
        rd(8'h09, r[7:0]);
        rd(8'h0a, {4'h0, r[11:8]});
        host_u.write_reg(8'h01, 8'h01);
        light(12'h123, 12'h456);
        rd(8'h09, r[7:0]);
        host_u.write_reg(8'h01, 8'h04);
        host_u.write_reg(8'h02, 8'h01);
        light(12'hfff, 12'hfff);
        repeat (2) @(posedge clk_sys);
        chk("and of one flag", 12'h0, {11'h0, int_oe});
        rd(8'h02, 8'h09);
        host_u.write_reg(8'h02, 8'h08);
        chk("or of one flag", 12'h1, {11'h0, int_oe});
        host_u.write_reg(8'h02, 8'h00);
        chk("flag released", 12'h0, {11'h0, int_oe});
        repeat (4) @(posedge clk_sys);
        conclude();
    end
endmodule
